// ==== src/gx_pkg.sv ====
// Shared constants and types of the eight-line two-wire GPIO expander
`default_nettype none

package gx_pkg;

    // ------------------------------------------------------------------
    // Register map (pointer values)
    // ------------------------------------------------------------------
    localparam logic [7:0] GX_OFS_CTRL = 8'h00;
    localparam logic [7:0] GX_OFS_DIR = 8'h01;
    localparam logic [7:0] GX_OFS_OUT = 8'h02;
    localparam logic [7:0] GX_OFS_PULL_EN = 8'h03;
    localparam logic [7:0] GX_OFS_PULL_UP = 8'h04;
    localparam logic [7:0] GX_OFS_INPUT = 8'h05;
    localparam logic [7:0] GX_OFS_MASK = 8'h06;
    localparam logic [7:0] GX_OFS_DEFAULT = 8'h07;
    localparam logic [7:0] GX_OFS_INT_STAT = 8'h08;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int GX_CTRL_SWRST_BIT = 0;
    localparam logic [7:0] GX_RST_DIR = 8'h00;
    localparam logic [7:0] GX_RST_OUT = 8'h00;
    localparam logic [7:0] GX_RST_PULL_EN = 8'h00;
    localparam logic [7:0] GX_RST_PULL_UP = 8'h00;
    localparam logic [7:0] GX_RST_MASK = 8'hFF;
    localparam logic [7:0] GX_RST_DEFAULT = 8'h00;

    // Target addresses per strap level; values are arbitrary
    localparam logic [6:0] GX_ADDR_STRAP_LOW = 7'h20;
    localparam logic [6:0] GX_ADDR_STRAP_HIGH = 7'h21;

    // Bit count values at a byte's last data bit and at its acknowledge slot
    localparam logic [3:0] GX_ACK_SLOT = 4'h8;
    localparam logic [3:0] GX_LAST_BIT = 4'h7;

    // Link rate ceiling and system clock, for reference only; the bench does not use them
    localparam int GX_SCL_MAX_HZ = 1000000;
    localparam int GX_SYS_HZ = 25000000;
    localparam int GX_SYS_PER_SCL = GX_SYS_HZ / GX_SCL_MAX_HZ;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        GX_IDLE,
        GX_ADDR,
        GX_REG,
        GX_WR,
        GX_RD
    } gx_phase_t;

    // Everything but the link shift word that enters the system domain from outside it
    typedef struct packed {
        logic tog;
        logic rst_n;
        logic addr_sel;
        logic scl;
        logic sda;
        logic [7:0] gpio;
    } gx_pins_t;

    typedef struct packed {
        logic [7:0] sh;
        logic tog;
    } gx_link_t;

    typedef struct packed {
        gx_phase_t phase;
        logic [3:0] cnt;
        logic rw;
        logic ack_go;
        logic sda_low;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic scl_prev;
        logic sda_prev;
        logic tog_prev;
        logic addr_done;
        logic addr_sel;
        logic [7:0] dir;
        logic [7:0] outv;
        logic [7:0] pull_en;
        logic [7:0] pull_up;
        logic [7:0] in_val;
        logic [7:0] mask;
        logic [7:0] dflt;
        logic int_act;
    } gx_core_t;

    localparam gx_core_t GX_CORE_RESET = '{
        phase: GX_IDLE,
        cnt: 4'h0,
        rw: 1'b0,
        ack_go: 1'b0,
        sda_low: 1'b0,
        tx: 8'h00,
        ptr: 8'h00,
        scl_prev: 1'b1,
        sda_prev: 1'b1,
        tog_prev: 1'b0,
        addr_done: 1'b0,
        addr_sel: 1'b0,
        dir: GX_RST_DIR,
        outv: GX_RST_OUT,
        pull_en: GX_RST_PULL_EN,
        pull_up: GX_RST_PULL_UP,
        in_val: 8'h00,
        mask: GX_RST_MASK,
        dflt: GX_RST_DEFAULT,
        int_act: 1'b0
    };

endpackage : gx_pkg

`default_nettype wire

// ==== src/gx_sync.sv ====
// Two-flop level synchroniser for a vector of independent bits
`default_nettype none

module gx_sync
    import gx_pkg::*;
#(
    parameter int W = 13
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [1:0][W-1:0] st_reg;
    logic [1:0][W-1:0] st_next;

    always_comb begin
        st_next = {st_reg[0], d};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Only the second stage leaves the module
    assign q = st_reg[1];

endmodule : gx_sync

`default_nettype wire

// ==== src/gx_link.sv ====
// Link-clock capture of the serial data line
`default_nettype none

module gx_link
    import gx_pkg::*;
(
    // Link clock and reset
    input wire logic scl,
    input wire logic rst,
    // Serial data in
    input wire logic sda,
    // To system domain
    output gx_link_t link
);

    gx_link_t st_reg;
    gx_link_t st_next;

    // Shift on every rising edge; the toggle tells the other domain a bit landed.
    // The shift word stays put for the whole low phase, long enough to be read.
    always_comb begin
        st_next.sh = {st_reg.sh[6:0], sda};
        st_next.tog = ~st_reg.tog;
    end

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link = st_reg;

endmodule : gx_link

`default_nettype wire

// ==== src/gx_expander.sv ====
// Eight-line GPIO expander with a two-wire serial target interface
// Function
// - Eight independent lines gpio_pin_0..7, each controlled over the serial link.
// - After reset every line is an input with its driver off.
// - Host writes per-line direction bits; the device applies them to pins.
// - Input register holds sampled pins; output register holds drive values.
// - Every register but the control register reads back its current contents over the serial link; control reads 00.
// - Interrupt goes low when an input differs from its stored default.
// - A masked line never causes the interrupt to assert.
// - Interrupt is active low and open drain, released otherwise.
// - Low on the reset pin returns logic to reset; host keeps it high.
// - Strapped address input chooses which target address the device answers.
// - Host programs pull-up or pull-down for each input line.
// - Serial target works for Standard and Fast transfers up to 1 MHz.
// - An output line is driven push-pull, both high and low.
`default_nettype none

module gx_expander
    import gx_pkg::*;
(
    // System clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Serial link
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    // Straps and reset pin
    input wire logic ADDR_SEL,
    input wire logic RESET_N,
    // GPIO lines
    input wire logic [7:0] GPIO_I,
    output logic [7:0] GPIO_O,
    output logic [7:0] GPIO_OE,
    output logic [7:0] PULL_EN,
    output logic [7:0] PULL_UP,
    // Interrupt
    output logic INT_N_O,
    output logic INT_N_OE
);

    // ------------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------------
    function automatic logic [7:0] reg_read(input gx_core_t s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            GX_OFS_CTRL: v = 8'h00;
            GX_OFS_DIR: v = s.dir;
            GX_OFS_OUT: v = s.outv;
            GX_OFS_PULL_EN: v = s.pull_en;
            GX_OFS_PULL_UP: v = s.pull_up;
            GX_OFS_INPUT: v = s.in_val;
            GX_OFS_MASK: v = s.mask;
            GX_OFS_DEFAULT: v = s.dflt;
            GX_OFS_INT_STAT: v = (s.in_val ^ s.dflt) & ~s.mask;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : reg_read

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------
    // Read-only and unmapped pointers fall through, so a stray write is harmless
    function automatic gx_core_t reg_write(input gx_core_t s, input logic [7:0] a,
            input logic [7:0] d);
        gx_core_t n;
        n = s;
        unique case (a)
            GX_OFS_CTRL: begin
                // Soft reset leaves the pointer and the protocol state alone
                if (d[GX_CTRL_SWRST_BIT]) begin
                    n.dir = GX_RST_DIR;
                    n.outv = GX_RST_OUT;
                    n.pull_en = GX_RST_PULL_EN;
                    n.pull_up = GX_RST_PULL_UP;
                    n.mask = GX_RST_MASK;
                    n.dflt = GX_RST_DEFAULT;
                end
            end
            GX_OFS_DIR: begin
                n.dir = d;
            end
            GX_OFS_OUT: begin
                n.outv = d;
            end
            GX_OFS_PULL_EN: begin
                n.pull_en = d;
            end
            GX_OFS_PULL_UP: begin
                n.pull_up = d;
            end
            GX_OFS_MASK: begin
                n.mask = d;
            end
            GX_OFS_DEFAULT: begin
                n.dflt = d;
            end
            default: begin
                n = s;
            end
        endcase
        return n;
    endfunction : reg_write

    // ------------------------------------------------------------------
    // Frame boundary
    // ------------------------------------------------------------------
    // A start or stop abandons any byte in flight and lets go of the data line
    function automatic gx_core_t frame_edge(input gx_core_t s, input gx_phase_t ph);
        gx_core_t n;
        n = s;
        n.phase = ph;
        n.cnt = 4'h0;
        n.sda_low = 1'b0;
        n.ack_go = 1'b0;
        return n;
    endfunction : frame_edge

    // ------------------------------------------------------------------
    // Link domain and crossings
    // ------------------------------------------------------------------
    gx_link_t link;
    gx_pins_t pins_raw;
    gx_pins_t samp;

    gx_link u_link (
        .scl(SCL),
        .rst(RST),
        .sda(SDA_I),
        .link(link)
    );

    // ------------------------------------------------------------------
    // Pin bundle
    // ------------------------------------------------------------------
    // Every pin and the link toggle ride one synchroniser, so they stay in step
    always_comb begin
        pins_raw.tog = link.tog;
        pins_raw.rst_n = RESET_N;
        pins_raw.addr_sel = ADDR_SEL;
        pins_raw.scl = SCL;
        pins_raw.sda = SDA_I;
        pins_raw.gpio = GPIO_I;
    end

    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------
    gx_sync #(
        .W($bits(gx_pins_t))
    ) u_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .d(pins_raw),
        .q(samp)
    );

    // ------------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------------
    gx_core_t st_reg;
    gx_core_t st_next;

    // ------------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------------
    logic [7:0] line_miss;
    logic start_det;
    logic stop_det;
    logic bit_evt;
    logic scl_fall;
    logic [6:0] my_addr;
    logic [7:0] rx_byte;

    always_comb begin
        start_det = samp.scl && st_reg.scl_prev && st_reg.sda_prev && !samp.sda;
        stop_det = samp.scl && st_reg.scl_prev && !st_reg.sda_prev && samp.sda;
        bit_evt = samp.tog != st_reg.tog_prev;
        scl_fall = st_reg.scl_prev && !samp.scl;
        my_addr = st_reg.addr_sel ? GX_ADDR_STRAP_HIGH : GX_ADDR_STRAP_LOW;
        rx_byte = link.sh;
    end

    always_comb begin
        st_next = st_reg;
        // --------------------------------------------------------------
        // Edge history
        // --------------------------------------------------------------
        st_next.scl_prev = samp.scl;
        st_next.sda_prev = samp.sda;
        st_next.tog_prev = samp.tog;

        // --------------------------------------------------------------
        // Strap capture
        // --------------------------------------------------------------
        // Strap caught once after each reset release
        if (!st_reg.addr_done) begin
            st_next.addr_sel = samp.addr_sel;
            st_next.addr_done = 1'b1;
        end

        // --------------------------------------------------------------
        // Input register and interrupt
        // --------------------------------------------------------------
        st_next.in_val = samp.gpio;
        // Level follows the mismatch, so it drops as soon as nothing unmasked differs
        st_next.int_act = |line_miss;

        // --------------------------------------------------------------
        // Serial protocol
        // --------------------------------------------------------------
        if (start_det) begin
            st_next = frame_edge(st_next, GX_ADDR);
        end else if (stop_det) begin
            st_next = frame_edge(st_next, GX_IDLE);
        end else if (bit_evt && st_reg.phase != GX_IDLE) begin
            if (st_reg.cnt == GX_ACK_SLOT) begin
                // ------------------------------------------------------
                // Acknowledge slot
                // ------------------------------------------------------
                st_next.cnt = 4'h0;
                unique case (st_reg.phase)
                    GX_ADDR: begin
                        if (!st_reg.ack_go) begin
                            st_next.phase = GX_IDLE;
                        end else if (st_reg.rw) begin
                            st_next.phase = GX_RD;
                            st_next.tx = reg_read(st_reg, st_reg.ptr);
                        end else begin
                            st_next.phase = GX_REG;
                        end
                    end
                    GX_REG: begin
                        st_next.phase = GX_WR;
                    end
                    GX_WR: begin
                        st_next.phase = GX_WR;
                    end
                    GX_RD: begin
                        // Controller's not-acknowledge ends the read
                        if (rx_byte[0]) begin
                            st_next.phase = GX_IDLE;
                        end else begin
                            st_next.ptr = st_reg.ptr + 8'h01;
                            st_next.tx = reg_read(st_reg, st_reg.ptr + 8'h01);
                        end
                    end
                    GX_IDLE: begin
                        st_next.phase = GX_IDLE;
                    end
                endcase
            end else begin
                // ------------------------------------------------------
                // Byte completion
                // ------------------------------------------------------
                st_next.cnt = st_reg.cnt + 4'h1;
                if (st_reg.cnt == GX_LAST_BIT) begin
                    unique case (st_reg.phase)
                        GX_ADDR: begin
                            st_next.ack_go = rx_byte[7:1] == my_addr;
                            st_next.rw = rx_byte[0];
                        end
                        GX_REG: begin
                            st_next.ptr = rx_byte;
                            st_next.ack_go = 1'b1;
                        end
                        GX_WR: begin
                            st_next.ack_go = 1'b1;
                            st_next.ptr = st_reg.ptr + 8'h01;
                            st_next = reg_write(st_next, st_reg.ptr, rx_byte);
                        end
                        GX_RD: begin
                            st_next.ack_go = 1'b0;
                        end
                        GX_IDLE: begin
                            st_next.ack_go = 1'b0;
                        end
                    endcase
                end
            end
        end else if (scl_fall) begin
            // Data only changes while the clock line is low
            if (st_reg.cnt == GX_ACK_SLOT) begin
                st_next.sda_low = st_reg.ack_go;
            end else if (st_reg.phase == GX_RD) begin
                st_next.sda_low = ~st_reg.tx[3'h7 - st_reg.cnt[2:0]];
            end else begin
                st_next.sda_low = 1'b0;
            end
        end

        // --------------------------------------------------------------
        // Reset pin
        // --------------------------------------------------------------
        // Reset pin returns everything, the strap capture included
        if (!samp.rst_n) begin
            st_next = GX_CORE_RESET;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            st_reg <= GX_CORE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    assign SDA_O = 1'b0;
    assign SDA_OE = st_reg.sda_low;

    // ------------------------------------------------------------------
    // Per-line drivers
    // ------------------------------------------------------------------
    // Push-pull drive, enabled per line by the direction register;
    // pulls apply to input lines only, so a driven line never fights one
    for (genvar i = 0; i < 8; i++) begin : g_line
        assign GPIO_O[i] = st_reg.outv[i];
        assign GPIO_OE[i] = st_reg.dir[i];
        assign PULL_EN[i] = st_reg.pull_en[i] & ~st_reg.dir[i];
        assign PULL_UP[i] = st_reg.pull_up[i];
        assign line_miss[i] = (st_reg.in_val[i] ^ st_reg.dflt[i]) & ~st_reg.mask[i];
    end

    // ------------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------------
    // Only ever pulls low; the board's pull-up gives the released level
    assign INT_N_O = 1'b0;
    assign INT_N_OE = st_reg.int_act;

endmodule : gx_expander

`default_nettype wire

// ==== tb/gx_expander_assertions.sv ====
// Port assertions of the GPIO expander
`default_nettype none

module gx_expander_assertions
    import gx_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Serial link and reset pin
    input wire logic SCL,
    input wire logic SDA_O,
    input wire logic SDA_OE,
    input wire logic RESET_N,
    // Lines and interrupt
    input wire logic [7:0] GPIO_I,
    input wire logic [7:0] GPIO_O,
    input wire logic [7:0] GPIO_OE,
    input wire logic [7:0] PULL_EN,
    input wire logic [7:0] PULL_UP,
    input wire logic INT_N_O,
    input wire logic INT_N_OE
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    chk_int_drain: assert property (INT_N_O == 1'b0)
        else $error("interrupt pin driven high");
    chk_sda_drain: assert property (SDA_O == 1'b0)
        else $error("data line driven high");
    chk_pull_gate: assert property ((PULL_EN & GPIO_OE) == 8'h00)
        else $error("pull enabled on an output line");
    chk_reset_outs: assert property ($past(RST) |-> GPIO_OE == 8'h00
        && GPIO_O == 8'h00 && !INT_N_OE)
        else $error("outputs not idle after reset");
    chk_resetn_clear: assert property (!RESET_N [*4] |-> GPIO_OE == 8'h00
        && PULL_UP == 8'h00 && !INT_N_OE)
        else $error("reset pin did not clear state");
    chk_int_cause: assert property (($stable(GPIO_I) && $stable(SCL)
        && $stable(RESET_N)) [*6] |=> $stable(INT_N_OE))
        else $error("interrupt moved without a cause");
    chk_cfg_quiet: assert property (($stable(SCL) && $stable(RESET_N)) [*8]
        |=> $stable(GPIO_OE) && $stable(GPIO_O) && $stable(PULL_UP))
        else $error("configuration moved without a transfer");
    chk_sda_edge: assert property ($changed(SDA_OE) |-> !$past(SCL, 2))
        else $error("data line changed during clock high");
endmodule : gx_expander_assertions

bind gx_expander gx_expander_assertions u_chk (.SYS_CLK, .RST, .SCL, .SDA_O, .SDA_OE,
    .RESET_N, .GPIO_I, .GPIO_O, .GPIO_OE, .PULL_EN, .PULL_UP, .INT_N_O, .INT_N_OE);

`default_nettype wire

// ==== tb/gx_host_model.sv ====
// Two-wire bus controller model
`default_nettype none

module gx_host_model (
    // Bus
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // Near 1 MHz; a faster clock breaks the 320 ns phase minimum
    localparam int HALF = 480;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic start;
        sda_low = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda_low = 1'b1;
        #HALF scl = 1'b0;
    endtask : start

    task automatic stop;
        #(HALF / 4) sda_low = 1'b1;
        #HALF scl = 1'b1;
        #HALF sda_low = 1'b0;
        #HALF;
    endtask : stop

    // Data moves only early in the low phase, HALF / 4 after the fall, so no false start is seen
    task automatic bit_io(input logic b, output logic r);
        #(HALF / 4) sda_low = ~b;
        #HALF scl = 1'b1;
        #HALF r = sda;
        scl = 1'b0;
    endtask : bit_io

    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    task automatic write_reg(input logic [6:0] a, input logic [7:0] p, d, output logic ack);
        logic k1, k2, k3;
        k2 = 1'b0;
        k3 = 1'b0;
        start();
        wr_byte({a, 1'b0}, k1);
        if (k1) begin
            wr_byte(p, k2);
            wr_byte(d, k3);
        end
        stop();
        ack = k1 & k2 & k3;
    endtask : write_reg

    task automatic read_reg(input logic [6:0] a, input logic [7:0] p, input int n,
            output logic [7:0] d [10], output logic ack);
        logic k1, k2, k3, r;
        start();
        wr_byte({a, 1'b0}, k1);
        wr_byte(p, k2);
        start();
        wr_byte({a, 1'b1}, k3);
        // Acknowledge every byte but the last, so the pointer walks on
        for (int j = 0; j < n; j++) begin
            for (int i = 7; i >= 0; i--) bit_io(1'b1, d[j][i]);
            bit_io(j == n - 1, r);
        end
        stop();
        ack = k1 & k2 & k3;
    endtask : read_reg
endmodule : gx_host_model

`default_nettype wire

// ==== tb/gx_expander_test.sv ====
// Self-checking bench of the GPIO expander
`default_nettype none

module gx_expander_test;
    timeunit 1ns;
    timeprecision 1ps;
    import gx_pkg::*;

    logic sys_clk = 1'b0, rst = 1'b1, addr_sel = 1'b0, reset_n = 1'b1;
    logic [7:0] ext = 8'h00;
    logic [6:0] dev = GX_ADDR_STRAP_LOW;
    logic sda_o, sda_oe, int_n_o, int_n_oe, ack;
    logic [7:0] gpio_i, gpio_o, gpio_oe, pull_en, pull_up, pin;
    logic [7:0] mdl [9];
    wire logic scl, sda_low;
    wire logic sda = ~(sda_low | sda_oe);
    int fails = 0, num_checks = 0;

    assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & ext);
    assign pin = (mdl[1] & mdl[2]) | (~mdl[1] & ext);

    gx_expander u_gx_expander (.SYS_CLK(sys_clk), .RST(rst), .SCL(scl), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_SEL(addr_sel), .RESET_N(reset_n),
        .GPIO_I(gpio_i), .GPIO_O(gpio_o), .GPIO_OE(gpio_oe), .PULL_EN(pull_en),
        .PULL_UP(pull_up), .INT_N_O(int_n_o), .INT_N_OE(int_n_oe));
    gx_host_model u_gx_host_model (.scl(scl), .sda_low(sda_low), .sda(sda));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [7:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rst_mdl;
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[6] = GX_RST_MASK;
    endtask : rst_mdl

    function automatic logic [7:0] exp_of(input int p);
        case (p)
            1, 2, 3, 4, 6, 7: return mdl[p];
            5: return pin;
            8: return (pin ^ mdl[7]) & ~mdl[6];
            default: return 8'h00;
        endcase
    endfunction : exp_of

    task automatic wr(input logic [7:0] p, d);
        u_gx_expander_test_wr: begin
            u_gx_host_model.write_reg(dev, p, d, ack);
            check("write ack", 8'h01, {7'h00, ack});
            if (p == GX_OFS_CTRL && d[0]) rst_mdl();
            else if (p inside {[1:4], 6, 7}) mdl[p] = d;
        end
    endtask : wr

    task automatic rd_all;
        logic [7:0] d [10];
        u_gx_host_model.read_reg(dev, 8'h00, 10, d, ack);
        check("read ack", 8'h01, {7'h00, ack});
        for (int p = 0; p < 10; p++) begin
            check($sformatf("reg %0d", p), exp_of(p), d[p]);
        end
    endtask : rd_all

    task automatic ports;
        repeat (8) @(posedge sys_clk);
        check("GPIO_OE", mdl[1], gpio_oe);
        check("GPIO_O", mdl[2], gpio_o);
        check("line level", pin, gpio_i);
        check("PULL_EN", mdl[3] & ~mdl[1], pull_en);
        check("PULL_UP", mdl[4], pull_up);
        check("INT", {7'h00, |exp_of(8)}, {7'h00, int_n_oe});
    endtask : ports

    initial begin
        void'($urandom(32'h3574EB40));
        rst_mdl();
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        ports();
        rd_all();
        repeat (4) begin
            for (int p = 1; p < 8; p++) if (p != 5) wr(p[7:0], 8'($urandom));
            @(posedge sys_clk) ext <= $urandom;
            ports();
            rd_all();
        end
        wr(1, 8'h00);
        wr(6, 8'h00);
        wr(7, ext);
        ports();
        @(posedge sys_clk) ext <= ext ^ 8'h10;
        ports();
        wr(6, 8'h10);
        ports();
        wr(8'h20, 8'h55);
        wr(0, 8'h01);
        rd_all();
        u_gx_host_model.write_reg(7'h21, 1, 8'hFF, ack);
        check("foreign ack", 8'h00, {7'h00, ack});
        wr(1, 8'h0F);
        @(posedge sys_clk) addr_sel <= 1'b1;
        reset_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        rst_mdl();
        ports();
        dev = GX_ADDR_STRAP_HIGH;
        wr(1, 8'hA5);
        u_gx_host_model.write_reg(GX_ADDR_STRAP_LOW, 1, 8'h00, ack);
        check("old address ack", 8'h00, {7'h00, ack});
        ports();
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        tally_and_finish();
    end
endmodule : gx_expander_test

`default_nettype wire
